/* usart_slave_pkg.sv */
package usart_slave_pkg;

  // register indices (printed offsets are not all multiples of four: byte address = index * 4)
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_RX_STATUS   = 8'h18;
  localparam logic [7:0] IDX_TX_HOLD     = 8'h19;
  localparam logic [7:0] IDX_RX_HOLD     = 8'h1A;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TX_STATUS   = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;
  // extra register of this block: core sleep state (bit 0), read-only
  localparam logic [7:0] IDX_SLEEP       = 8'hA0;

  localparam int unsigned ADDR_W = 10;

  // peripheral_irq_flags / peripheral_irq_enables
  localparam int unsigned BIT_RX_FLAG = 5;
  localparam int unsigned BIT_TX_FLAG = 4;

  // receive_status_control
  localparam int unsigned BIT_SERIAL_PORT_ENABLE  = 7;
  localparam int unsigned BIT_RX9   = 6;
  localparam int unsigned BIT_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int unsigned BIT_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int unsigned BIT_FRAMING_ERROR  = 2;
  localparam int unsigned BIT_OVERRUN_ERROR  = 1;
  localparam int unsigned BIT_RX_NINTH_BIT  = 0;

  // transmit_status_control
  localparam int unsigned BIT_CLOCK_SOURCE_MASTER  = 7;
  localparam int unsigned BIT_TX9   = 6;
  localparam int unsigned BIT_TRANSMIT_ENABLE_BIT  = 5;
  localparam int unsigned BIT_SYNC  = 4;
  localparam int unsigned BIT_BAUD_HIGH_SPEED  = 2;
  localparam int unsigned BIT_TX_SHIFT_EMPTY  = 1;
  localparam int unsigned BIT_TX_NINTH_BIT  = 0;

  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] MASK_RX_CTRL  = 8'hF0;
  localparam logic [7:0] MASK_TX_CTRL  = 8'hF5;
  localparam logic [7:0] MASK_IRQ_EN   = 8'h30;

  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned RX_DEPTH   = 2;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;

endpackage

/* usart_slave_shifter.sv */
`timescale 1ns/100ps
// serial engine on the sampled shift clock; bits move on its falling edge
module usart_slave_shifter
  import usart_slave_pkg::*;
#(
  parameter int unsigned WIDTH = 9
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             fall_i,
  input  wire logic             data_i,
  input  wire logic             nine_i,
  input  wire logic             rx_en_i,
  input  wire logic             tx_en_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_word_i,
  output logic                  busy_o,
  output logic                  tx_bit_o,
  output logic                  tx_done_o,
  output logic                  rx_done_o,
  output logic [WIDTH-1:0]      rx_word_o
);

  logic [WIDTH-1:0] tsr_q;
  logic [3:0]       tx_cnt_q;
  logic [WIDTH-1:0] rsr_q;
  logic [3:0]       rx_cnt_q;
  wire  [3:0]       last_cnt = nine_i ? 4'(WIDTH - 1) : 4'(WIDTH - 2);
  wire              tx_last  = fall_i && busy_o && (tx_cnt_q == last_cnt);
  wire              rx_last  = fall_i && rx_en_i && (rx_cnt_q == last_cnt);
  wire [WIDTH-1:0]  rx_shift = {data_i, rsr_q[WIDTH-1:1]};

  assign tx_bit_o = tsr_q[0];

  always_ff @(posedge clk_i)
  begin
    tx_done_o <= 1'b0;
    if (rst_i || !tx_en_i)
    begin
      busy_o   <= 1'b0;
      tsr_q    <= '0;
      tx_cnt_q <= '0;
    end
    else if (load_i)
    begin
      busy_o   <= 1'b1;
      tsr_q    <= load_word_i;
      tx_cnt_q <= '0;
    end
    else if (tx_last)
    begin
      busy_o    <= 1'b0;
      tx_done_o <= 1'b1;
    end
    else if (fall_i && busy_o)
    begin
      tsr_q    <= {1'b0, tsr_q[WIDTH-1:1]}; // R22
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rx_done_o <= 1'b0;
    if (rst_i || !rx_en_i)
    begin
      rsr_q    <= '0;
      rx_cnt_q <= '0;
    end
    else if (fall_i) // R19
    begin
      rsr_q    <= rx_shift; // R22
      rx_cnt_q <= rx_last ? 4'h0 : rx_cnt_q + 4'h1;
      if (rx_last)
      begin
        rx_done_o <= 1'b1;
        rx_word_o <= nine_i ? rx_shift : {1'b0, rx_shift[WIDTH-1:1]};
      end
    end
  end

endmodule // usart_slave_shifter

/* usart_sync_slave.sv */
`timescale 1ns/100ps
// Function
// R1: slave mode behaves like master mode except clock source and sleep.
// R2: first of two written words moves to shift register at once, even asleep.
// R3: second word waits in holding register; tx pending flag stays clear.
// R4: after first word leaves, second loads and tx pending flag sets.
// R5: tx pending with tx irq enable wakes core; global enable vectors to 0004h.
// R6: software selects sync, port enable, clears clock master bit.
// R7: software clears both receive enables before slave transmission.
// R8: software sets tx ninth enable and loads ninth bit before data byte.
// R9: transmission starts only after transmit holding register is loaded.
// R10: single receive enable is ignored in slave mode.
// R11: continuous receive set before sleep still receives words during sleep.
// R12: received word moves to holding buffer; rx irq wakes core, vectors.
// R13: rx ready flag sets on completion; irq only with rx irq enable.
// R14: software sets rx irq enable, then continuous receive enable.
// R15: software sets rx ninth enable before enabling reception.
// R16: software reads status for ninth bit and errors before data.
// R17: clearing continuous receive clears latched receive errors.
// R18: shift clock comes from outside on the clock pin.
// R19: data pin sampled at each falling edge of shift clock.
// R20: two-entry receive buffer; third word when full sets overrun, discarded.
// R21: overrun blocks all transfers into receive buffer.
// R22: least significant bit first; ninth bit follows eighth.
module usart_sync_slave
  import usart_slave_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        shift_clock_pin_i,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe_o,
  input  wire logic        global_irq_enable_i,
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             irq_req_o,
  output logic [15:0]      irq_vector_o
);

  localparam int unsigned W = DATA_BITS + 1;

  logic       ck_s1_q, ck_s2_q, ck_s3_q;
  logic       dt_s1_q, dt_s2_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] tx_ctrl_q;
  logic [7:0] irq_en_q;
  logic [7:0] baud_q;
  logic       sleep_q;
  logic [W-1:0] hold_q;
  logic       hold_full_q;
  logic [W-1:0] fifo_q [RX_DEPTH];
  logic [1:0] cnt_q;
  logic       rd_ptr_q;
  logic       overrun_error_q;
  logic       framing_error_q;
  logic       tx_flag_q;
  logic       tx_busy;
  logic       tx_bit;
  logic       tx_done;
  logic       rx_done;
  logic [W-1:0] rx_word;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // bus decode
  wire              bus_req   = cyc_i && stb_i && !ack_o;
  wire              wr_req    = bus_req && we_i && sel_i[0];
  wire              rd_req    = bus_req && !we_i;
  wire [ADDR_W-1:0] a         = adr_i[ADDR_W-1:0];
  wire [7:0]        wd        = dat_i[7:0];
  wire              wr_rxc    = wr_req && hit(a, IDX_RX_STATUS);
  wire              wr_txc    = wr_req && hit(a, IDX_TX_STATUS);
  wire              wr_hold   = wr_req && hit(a, IDX_TX_HOLD);
  wire              rd_rxh    = rd_req && hit(a, IDX_RX_HOLD);

  // mode decode; the port runs only with sync set and the clock master bit clear
  wire port_on   = rx_ctrl_q[BIT_SERIAL_PORT_ENABLE] && tx_ctrl_q[BIT_SYNC] && !tx_ctrl_q[BIT_CLOCK_SOURCE_MASTER]; // R6
  wire continuous_receive_enable      = rx_ctrl_q[BIT_CONTINUOUS_RECEIVE_ENABLE];
  wire rx_en     = port_on && continuous_receive_enable; // R10 R11
  wire tx_en     = port_on && tx_ctrl_q[BIT_TRANSMIT_ENABLE_BIT];
  wire ck_fall   = ck_s3_q && !ck_s2_q; // R18
  wire rx_full   = cnt_q == 2'(RX_DEPTH);
  wire push      = rx_done && !overrun_error_q && !rx_full; // R12 R21
  wire overrun   = rx_done && !overrun_error_q && rx_full; // R20
  wire pop       = rd_rxh && cnt_q != 2'h0;
  wire continuous_receive_enable_drop = wr_rxc && continuous_receive_enable && !wd[BIT_CONTINUOUS_RECEIVE_ENABLE];
  wire tx_load   = tx_en && hold_full_q && !tx_busy && !tx_done; // R2 R9
  wire rx_flag   = cnt_q != 2'h0; // R13
  wire [W-1:0] head = fifo_q[rd_ptr_q];
  wire [7:0] flags = {2'b00, rx_flag, tx_flag_q, 4'h0};
  wire pend      = (rx_flag && irq_en_q[BIT_RX_FLAG]) || (tx_flag_q && irq_en_q[BIT_TX_FLAG]); // R5 R13
  wire [7:0] rx_stat = {rx_ctrl_q[7:4], 1'b0, framing_error_q, overrun_error_q, head[DATA_BITS]};
  wire [7:0] tx_stat = {tx_ctrl_q[7:2], !tx_busy, tx_ctrl_q[BIT_TX_NINTH_BIT]};

  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = RST_ZERO;
    if (hit(a, IDX_IRQ_FLAGS))
      rd_mux = flags;
    else if (hit(a, IDX_RX_STATUS))
      rd_mux = rx_stat;
    else if (hit(a, IDX_RX_HOLD))
      rd_mux = head[7:0];
    else if (hit(a, IDX_IRQ_ENABLES))
      rd_mux = irq_en_q;
    else if (hit(a, IDX_TX_STATUS))
      rd_mux = tx_stat;
    else if (hit(a, IDX_BAUD_DIV))
      rd_mux = baud_q;
    else if (hit(a, IDX_SLEEP))
      rd_mux = {7'h00, sleep_q};
  end

  // pin synchronisers; third stage only for edge finding
  always_ff @(posedge clk_i)
  begin
    ck_s1_q <= shift_clock_pin_i;
    ck_s2_q <= ck_s1_q;
    ck_s3_q <= ck_s2_q;
    dt_s1_q <= serial_data_pin_i;
    dt_s2_q <= dt_s1_q;
    sleep_q <= sleep_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= rd_req ? {24'h000000, rd_mux} : '0;
    end
  end

  // control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_ctrl_q <= RST_ZERO;
      tx_ctrl_q <= RST_TX_STATUS;
      irq_en_q  <= RST_ZERO;
      baud_q    <= RST_ZERO;
    end
    else
    begin
      if (wr_rxc)
        rx_ctrl_q <= wd & MASK_RX_CTRL;
      if (wr_txc)
        tx_ctrl_q <= wd & MASK_TX_CTRL;
      if (wr_req && hit(a, IDX_IRQ_ENABLES))
        irq_en_q <= wd & MASK_IRQ_EN;
      if (wr_req && hit(a, IDX_BAUD_DIV))
        baud_q <= wd;
    end
  end

  // transmit holding register and pending flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_q      <= '0;
      hold_full_q <= 1'b0;
      tx_flag_q   <= 1'b0;
    end
    else
    begin
      if (tx_load)
      begin
        hold_full_q <= 1'b0;
        // flag sets on the first load too; clear while a written word sits, set once it moves
        tx_flag_q   <= 1'b1; // R3 R4
      end
      if (wr_hold)
      begin
        // ninth bit captured at write time, so it must be set first
        hold_q      <= {tx_ctrl_q[BIT_TX_NINTH_BIT], wd}; // R8
        hold_full_q <= 1'b1;
        tx_flag_q   <= 1'b0;
      end
    end
  end

  // receive buffer, overrun and framing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q    <= '0;
      rd_ptr_q <= 1'b0;
      overrun_error_q   <= 1'b0;
      framing_error_q   <= 1'b0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end
    else
    begin
      if (push)
        fifo_q[1'(rd_ptr_q + cnt_q[0])] <= rx_word;
      if (pop)
        rd_ptr_q <= !rd_ptr_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
      // overrun set wins over the clear by software
      if (overrun)
        overrun_error_q <= 1'b1; // R20
      else if (continuous_receive_enable_drop)
        overrun_error_q <= 1'b0; // R17
      if (continuous_receive_enable_drop)
        framing_error_q <= 1'b0; // R17
    end
  end

  // serial output, vector and wake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_data_pin_o    <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      wake_o               <= 1'b0;
      irq_req_o            <= 1'b0;
      irq_vector_o         <= '0;
    end
    else
    begin
      serial_data_pin_o    <= tx_bit;
      serial_data_pin_oe_o <= tx_busy && !rx_en; // R7
      wake_o               <= pend && sleep_q; // R5 R12
      irq_req_o            <= pend && global_irq_enable_i;
      irq_vector_o         <= (pend && global_irq_enable_i) ? VECTOR_ADDR : '0;
    end
  end

  usart_slave_shifter #(
    .WIDTH (W)
  ) u_shifter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .fall_i      (ck_fall),
    .data_i      (dt_s2_q),
    .nine_i      (rx_en ? rx_ctrl_q[BIT_RX9] : tx_ctrl_q[BIT_TX9]), // R15
    .rx_en_i     (rx_en),
    .tx_en_i     (tx_en), // R1
    .load_i      (tx_load),
    .load_word_i (hold_q),
    .busy_o      (tx_busy),
    .tx_bit_o    (tx_bit),
    .tx_done_o   (tx_done),
    .rx_done_o   (rx_done),
    .rx_word_o   (rx_word)
  );

endmodule // usart_sync_slave

/* usart_sync_slave_chk.sv */
`timescale 1ns/100ps
module usart_sync_slave_chk
  import usart_slave_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] adr_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        global_irq_enable_i,
  input  wire logic        sleep_i,
  input  wire logic        wake_o,
  input  wire logic        irq_req_o,
  input  wire logic [15:0] irq_vector_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence

  chk_ack_once: assert property (s_req |=> s_ans)
    else $error("ack missing or longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_read_width: assert property (ack_o && !$past(we_i) |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i[9:0] == 10'h3FC) |-> dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  chk_vector_set: assert property (irq_req_o |-> irq_vector_o == VECTOR_ADDR)
    else $error("vector wrong while request high");
  chk_vector_clear: assert property (!irq_req_o |-> irq_vector_o == 16'h0000)
    else $error("vector not zero while idle");
  chk_irq_global: assert property (irq_req_o |-> $past(global_irq_enable_i))
    else $error("request without global enable");
  chk_wake_sleep: assert property (wake_o |-> $past(sleep_i, 2))
    else $error("wake while awake");
endmodule // usart_sync_slave_chk

bind usart_sync_slave usart_sync_slave_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .global_irq_enable_i(global_irq_enable_i),
  .sleep_i(sleep_i), .wake_o(wake_o), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o));

/* usart_shift_master.sv */
`timescale 1ns/100ps
module usart_shift_master
(
  output logic      sck_o,
  output logic      sdo_o,
  input  wire logic sdi_i
);
  initial
  begin
    sck_o = 1'b0;
    sdo_o = 1'b0;
  end

  // clock stands low between frames; data moves on the rise so it is stable over the fall
  task automatic run(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    for (int i = 0; i < n; i++)
    begin
      #62.5 sck_o = 1'b1;
      sdo_o = tx[i];
      #62.5 sck_o = 1'b0;
      rx[i] = sdi_i;
    end
    #62.5 sdo_o = ~sdo_o;
  endtask
endmodule // usart_shift_master

/* usart_sync_slave_mode_tb.sv */
`timescale 1ns/100ps
module usart_sync_slave_mode_tb
  import usart_slave_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic [31:0] adr_i;
  logic [31:0] dat_i;
  logic [3:0]  sel_i;
  logic        we_i;
  logic        cyc_i;
  logic        stb_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        global_irq_enable;
  logic        sleep;
  logic        wake;
  logic        irq;
  logic [15:0] vec;
  logic [8:0]  w;
  int          n_fail;
  int          checks;

  usart_sync_slave u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .shift_clock_pin_i(sck), .serial_data_pin_i(sdi),
    .serial_data_pin_o(sdo), .serial_data_pin_oe_o(), .global_irq_enable_i(global_irq_enable), .sleep_i(sleep),
    .wake_o(wake), .irq_req_o(irq), .irq_vector_o(vec));
  usart_shift_master u_m (.sck_o(sck), .sdo_o(sdi), .sdi_i(sdo));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {22'h000000, idx, 2'b00};
    dat_i <= {24'h000000, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n == 50)
      n_fail++;
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    wb(1'b1, idx, d, rd);
  endtask

  task automatic rd_cmp(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    wb(1'b0, idx, 8'h00, rd);
    cmp_val({8'h00, rd}, {8'h00, exp});
  endtask

  task automatic t_regs;
    rd_cmp(IDX_TX_STATUS, RST_TX_STATUS);
    rd_cmp(IDX_IRQ_FLAGS, RST_ZERO);
    rd_cmp(IDX_IRQ_ENABLES, RST_ZERO);
    wr(IDX_BAUD_DIV, 8'h5A);
    rd_cmp(IDX_BAUD_DIV, 8'h5A);
    wr(8'hFF, 8'h33);
    rd_cmp(8'hFF, 8'h00);
  endtask

  task automatic t_tx;
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_TX_STATUS, 8'h30);
    wr(IDX_IRQ_ENABLES, 8'h10);
    wr(IDX_TX_HOLD, 8'hC3);
    wr(IDX_TX_HOLD, 8'h5A);
    sleep <= 1'b1;
    global_irq_enable <= 1'b1;
    rd_cmp(IDX_IRQ_FLAGS, 8'h00);
    cmp_bit(wake, 1'b0);
    u_m.run(8, 9'h000, w);
    cmp_val({8'h00, w[7:0]}, 16'h00C3);
    repeat (10) @(posedge clk_i);
    cmp_bit(wake, 1'b1);
    cmp_bit(irq, 1'b1);
    cmp_val(vec, 16'h0004);
    u_m.run(8, 9'h000, w);
    cmp_val({8'h00, w[7:0]}, 16'h005A);
    rd_cmp(IDX_IRQ_FLAGS, 8'h10);
  endtask

  task automatic t_rx;
    wr(IDX_TX_STATUS, 8'h10);
    wr(IDX_IRQ_ENABLES, 8'h00);
    wr(IDX_RX_STATUS, 8'hB0);
    u_m.run(8, 9'h0A5, w);
    repeat (10) @(posedge clk_i);
    cmp_bit(irq, 1'b0);
    rd_cmp(IDX_IRQ_FLAGS, 8'h30);
    wr(IDX_IRQ_ENABLES, 8'h20);
    repeat (2) @(posedge clk_i);
    cmp_bit(wake, 1'b1);
    u_m.run(8, 9'h03C, w);
    u_m.run(8, 9'h077, w);
    u_m.run(8, 9'h011, w);
    repeat (10) @(posedge clk_i);
    rd_cmp(IDX_RX_STATUS, 8'hB2);
    rd_cmp(IDX_RX_HOLD, 8'hA5);
    rd_cmp(IDX_RX_HOLD, 8'h3C);
    rd_cmp(IDX_IRQ_FLAGS, 8'h10);
    wr(IDX_RX_STATUS, 8'h80);
    rd_cmp(IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'hD0);
    u_m.run(9, 9'h1A5, w);
    repeat (10) @(posedge clk_i);
    rd_cmp(IDX_RX_STATUS, 8'hD1);
    rd_cmp(IDX_RX_HOLD, 8'hA5);
  endtask

  task automatic t_tx9;
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_TX_STATUS, 8'h71);
    wr(IDX_TX_HOLD, 8'h96);
    u_m.run(9, 9'h000, w);
    cmp_val({7'h00, w}, 16'h0196);
  endtask

  // bounded well above the eight frames and few dozen bus cycles of the run
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end

  initial
  begin
    n_fail = 0;
    checks = 0;
    rst_i = 1'b1;
    adr_i = 32'h00000000;
    dat_i = 32'h00000000;
    sel_i = 4'hF;
    we_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    global_irq_enable = 1'b0;
    sleep = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_tx9();
    close_out();
  end
endmodule // usart_sync_slave_mode_tb
